// ===== src/integ_pkg.sv
// Purpose: constants and carriers for the integration and trigger counters
// Assumes: one 50 MHz clock, active-low asynchronous reset
// Notes: all pulse-train and encoder inputs arrive from outside the clock domain
//
// Behaviour
// - Two pairs of 32-bit counters, signal and reference, only one pair counting.
// - Each trigger swaps pairs: idle pair starts, active pair stops.
// - Stopped pair is latched for the processor, then both its counters clear.
// - Over-limit indicators latch until host clear, function button or gain change.
// - Time mode advances the trigger-source counter once per millisecond.
// - Quadrature decoder gives four count pulses per encoder cycle.
// - During initialisation an encoder index pulse clears the position counter.
// - Encoder pulses drive the same trigger-source counter as the timer.
// - Trigger-source counter is 24 bits, top bit being the sign.
// - External alignment input clears the trigger-source counter in both modes.
// - Processor loads a set value; compare pulse issues when count reaches it.
// - Two logic outputs carry forward and backward motor orders.
// - Autonomous serial mode triggers continuously every 300 ms.
// - Bus execute-trigger command acts as a software alignment pulse.
package integ_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int AUTO_PERIOD_MS = 300;
    localparam int POS_W = 24;
    localparam int CNT_W = 32;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [POS_W-1:0] POS_RST = 24'h00_0000;

    typedef enum logic [1:0] {
        SRC_TIMER = 2'b00,
        SRC_ENCODER = 2'b01,
        SRC_AUTO = 2'b10
    } trig_src_t;

    // Latched counts of the stopped pair
    typedef struct packed {
        logic [CNT_W-1:0] sig_count;
        logic [CNT_W-1:0] ref_count;
    } count_pair_t;

    // Motor orders
    typedef struct packed {
        logic motor_forward_order;
        logic motor_backward_order;
    } motor_t;
endpackage

// ===== src/integration_trigger_counters.sv
// Purpose: integration counter pairs and trigger-source counter
// Assumes: external pulse inputs slower than a quarter of ref_clk
// Notes: counts are taken on edges seen after a three-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
module integration_trigger_counters #(
    parameter int TICK_CYCLES = integ_pkg::TICK_CYC,
    parameter int AUTO_MS = integ_pkg::AUTO_PERIOD_MS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic signal_pulse_train,
    input wire logic reference_pulse_train,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_index,
    input wire logic ext_align,
    input wire logic over_pos,
    input wire logic over_neg,
    input wire logic function_button,
    input wire logic gain_change,
    input wire logic host_ovr_clear,
    input wire logic get_cmd,
    input wire logic init_mode,
    input wire integ_pkg::trig_src_t trig_src,
    input wire logic set_load,
    input wire logic [integ_pkg::POS_W-1:0] set_value,
    input wire integ_pkg::motor_t motor_cmd,
    output integ_pkg::count_pair_t counts,
    output logic counts_valid,
    output logic trigger,
    output logic compare,
    output logic [integ_pkg::POS_W-1:0] position,
    output logic ovr_pos_ff,
    output logic ovr_neg_ff,
    output integ_pkg::motor_t motor_out
);
    // ----------------------------------------------------------------
    // Reset release and synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_i_n;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) rst_sync_ff <= 2'h0;
        else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_i_n = rst_sync_ff[1];

    // Seven pin inputs, three stages each; stage 0 feeds only stage 1
    localparam int NP = 7;
    logic [NP-1:0] s0_ff, s1_ff, s2_ff, lvl_ff;
    logic [NP-1:0] pins, nxt_lvl;
    assign pins = {signal_pulse_train, reference_pulse_train, enc_a, enc_b,
                   enc_index, ext_align, over_pos | (over_neg & 1'b0)};
    always_comb begin
        nxt_lvl = lvl_ff;
        for (int i = 0; i < NP; i++) begin
            if (s1_ff[i] == s2_ff[i]) nxt_lvl[i] = s2_ff[i];
        end
    end
    always_ff @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            s0_ff <= '0;
            s1_ff <= '0;
            s2_ff <= '0;
            lvl_ff <= '0;
        end else begin
            s0_ff <= pins;
            s1_ff <= s0_ff;
            s2_ff <= s1_ff;
            lvl_ff <= nxt_lvl;
        end
    end
    // Negative over-limit has its own chain to keep the vector simple
    logic [2:0] neg_sync_ff;
    logic neg_lvl_ff;
    always_ff @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            neg_sync_ff <= 3'h0;
            neg_lvl_ff <= 1'b0;
        end else begin
            neg_sync_ff <= {neg_sync_ff[1:0], over_neg};
            if (neg_sync_ff[1] == neg_sync_ff[2]) neg_lvl_ff <= neg_sync_ff[2];
        end
    end

    // Filtered levels and edges
    logic [NP-1:0] prev_ff;
    always_ff @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) prev_ff <= '0;
        else prev_ff <= lvl_ff;
    end
    logic sig_rise, ref_rise, idx_rise, align_rise, a_l, b_l, a_p, b_p;
    assign sig_rise = lvl_ff[6] & ~prev_ff[6];
    assign ref_rise = lvl_ff[5] & ~prev_ff[5];
    assign a_l = lvl_ff[4];
    assign b_l = lvl_ff[3];
    assign a_p = prev_ff[4];
    assign b_p = prev_ff[3];
    assign idx_rise = lvl_ff[2] & ~prev_ff[2];
    assign align_rise = lvl_ff[1] & ~prev_ff[1];

    // ----------------------------------------------------------------
    // Quadrature decoder
    // ----------------------------------------------------------------
    logic enc_step, enc_up;
    // Every valid transition of either channel counts: four per cycle
    always_comb begin
        enc_step = (a_l ^ a_p) ^ (b_l ^ b_p);
        enc_up = a_p ^ b_l;
    end

    // ----------------------------------------------------------------
    // Millisecond timer and trigger-source counter
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt_ff, nxt_tick_cnt;
    logic ms_tick;
    logic [integ_pkg::POS_W-1:0] pos_ff, nxt_pos, set_ff, nxt_set;
    logic [15:0] auto_ff, nxt_auto;
    logic trig_ff, nxt_trig, cmp_ff, nxt_cmp, align;
    logic [31:0] tick_last;
    assign tick_last = 32'(TICK_CYCLES - 1);
    assign ms_tick = (tick_cnt_ff == tick_last);
    assign align = align_rise | get_cmd;

    always_comb begin
        nxt_tick_cnt = ms_tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
        nxt_pos = pos_ff;
        nxt_set = set_load ? set_value : set_ff;
        nxt_auto = auto_ff;
        nxt_trig = 1'b0;
        nxt_cmp = 1'b0;
        case (trig_src)
            integ_pkg::SRC_ENCODER: begin
                // Shared counter, signed 24-bit position
                if (enc_step) nxt_pos = enc_up ? pos_ff + 24'h00_0001 : pos_ff - 24'h00_0001;
                if (enc_step && !init_mode && nxt_pos == set_ff) nxt_cmp = 1'b1;
                if (init_mode && idx_rise) nxt_pos = integ_pkg::POS_RST;
            end
            integ_pkg::SRC_AUTO: begin
                if (ms_tick) begin
                    if (auto_ff == 16'(AUTO_MS - 1)) begin
                        nxt_auto = 16'h0000;
                        nxt_trig = 1'b1;
                    end else begin
                        nxt_auto = auto_ff + 16'h0001;
                    end
                end
            end
            default: begin
                if (ms_tick) begin
                    nxt_pos = pos_ff + 24'h00_0001;
                    if (nxt_pos == set_ff) nxt_cmp = 1'b1;
                end
            end
        endcase
        // A cleared count no longer matches, so no compare with it
        if (align) begin
            nxt_pos = integ_pkg::POS_RST;
            nxt_auto = 16'h0000;
            nxt_cmp = 1'b0;
        end
        // Compare of the trigger-source logic doubles as the trigger
        if (nxt_cmp) nxt_trig = 1'b1;
    end
    always_ff @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            tick_cnt_ff <= 32'h0000_0000;
            pos_ff <= integ_pkg::POS_RST;
            set_ff <= integ_pkg::POS_RST;
            auto_ff <= 16'h0000;
            trig_ff <= 1'b0;
            cmp_ff <= 1'b0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            pos_ff <= nxt_pos;
            set_ff <= nxt_set;
            auto_ff <= nxt_auto;
            trig_ff <= nxt_trig;
            cmp_ff <= nxt_cmp;
        end
    end
    assign trigger = trig_ff;
    assign compare = cmp_ff;
    assign position = pos_ff;

    // ----------------------------------------------------------------
    // Counter pairs
    // ----------------------------------------------------------------
    logic sel_ff, nxt_sel;
    logic [integ_pkg::CNT_W-1:0] sig_ff [2], ref_ff [2];
    logic [integ_pkg::CNT_W-1:0] nxt_sig [2], nxt_ref [2];
    integ_pkg::count_pair_t out_ff, nxt_out;
    logic val_ff, nxt_val;
    // Active pair counts; on trigger the stopped pair is latched and cleared
    always_comb begin
        nxt_sel = trig_ff ? ~sel_ff : sel_ff;
        nxt_out = out_ff;
        nxt_val = 1'b0;
        for (int p = 0; p < 2; p++) begin
            nxt_sig[p] = sig_ff[p];
            nxt_ref[p] = ref_ff[p];
            if (sel_ff == p[0]) begin
                if (sig_rise) nxt_sig[p] = sig_ff[p] + 32'h0000_0001;
                if (ref_rise) nxt_ref[p] = ref_ff[p] + 32'h0000_0001;
            end else begin
                // Idle pair held at zero after its transfer
                nxt_sig[p] = integ_pkg::CNT_RST;
                nxt_ref[p] = integ_pkg::CNT_RST;
            end
        end
        if (trig_ff) begin
            nxt_out.sig_count = nxt_sig[sel_ff];
            nxt_out.ref_count = nxt_ref[sel_ff];
            nxt_val = 1'b1;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            sel_ff <= 1'b0;
            sig_ff[0] <= integ_pkg::CNT_RST;
            sig_ff[1] <= integ_pkg::CNT_RST;
            ref_ff[0] <= integ_pkg::CNT_RST;
            ref_ff[1] <= integ_pkg::CNT_RST;
            out_ff <= '0;
            val_ff <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
            sig_ff <= nxt_sig;
            ref_ff <= nxt_ref;
            out_ff <= nxt_out;
            val_ff <= nxt_val;
        end
    end
    assign counts = out_ff;
    assign counts_valid = val_ff;

    // ----------------------------------------------------------------
    // Overrange latches and motor orders
    // ----------------------------------------------------------------
    logic ovr_clr, nxt_op, nxt_on;
    integ_pkg::motor_t mot_ff;
    assign ovr_clr = host_ovr_clear | function_button | gain_change;
    // Set beats clear so a coincident overrange is not lost
    always_comb begin
        nxt_op = lvl_ff[0] | (ovr_pos_ff & ~ovr_clr);
        nxt_on = neg_lvl_ff | (ovr_neg_ff & ~ovr_clr);
    end
    always_ff @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            ovr_pos_ff <= 1'b0;
            ovr_neg_ff <= 1'b0;
            mot_ff <= '0;
        end else begin
            ovr_pos_ff <= nxt_op;
            ovr_neg_ff <= nxt_on;
            // Never both directions at once
            mot_ff <= motor_cmd.motor_forward_order & motor_cmd.motor_backward_order
                ? '0 : motor_cmd;
        end
    end
    assign motor_out = mot_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_swap;
        @(posedge ref_clk) disable iff (!rst_i_n)
        trig_ff |=> sel_ff != $past(sel_ff);
    endproperty
    a_swap: assert property (p_swap) else $error("pair not swapped");
    property p_idle_clear;
        @(posedge ref_clk) disable iff (!rst_i_n)
        trig_ff |=> ##1 (sig_ff[~sel_ff] == 32'h0000_0000);
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle pair not cleared");
    property p_latch;
        @(posedge ref_clk) disable iff (!rst_i_n)
        trig_ff |=> counts_valid;
    endproperty
    a_latch: assert property (p_latch) else $error("counts not presented");
    property p_ovr;
        @(posedge ref_clk) disable iff (!rst_i_n)
        lvl_ff[0] |=> ovr_pos_ff;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrange not latched");
    property p_ovr_hold;
        @(posedge ref_clk) disable iff (!rst_i_n)
        ovr_pos_ff && !ovr_clr |=> ovr_pos_ff;
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("overrange dropped");
    property p_align;
        @(posedge ref_clk) disable iff (!rst_i_n)
        align |=> pos_ff == 24'h00_0000;
    endproperty
    a_align: assert property (p_align) else $error("align did not clear");
    property p_cmp;
        @(posedge ref_clk) disable iff (!rst_i_n)
        cmp_ff |-> pos_ff == $past(set_ff);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare without match");
    property p_motor;
        @(posedge ref_clk) disable iff (!rst_i_n)
        !(motor_out.motor_forward_order && motor_out.motor_backward_order);
    endproperty
    a_motor: assert property (p_motor) else $error("both motor orders");
endmodule // integration_trigger_counters
`default_nettype wire

// ===== testbench/proc_model.sv
// Purpose: local processor beside the trigger logic
// Assumes: loads land on the falling edge of ref_clk
// Notes: set values stay small, so periods stay legal
`timescale 1ns/1ps
`default_nettype none
module proc_model (
    input wire logic ref_clk,
    input wire logic counts_valid,
    input wire integ_pkg::count_pair_t counts,
    output logic set_load,
    output logic [integ_pkg::POS_W-1:0] set_value,
    output integ_pkg::count_pair_t got
);
    // Idle bus until the first load
    initial begin
        set_load = 1'b0;
        set_value = 24'h00_0000;
    end
    // Load strobe for one cycle; value is held afterwards
    task automatic load(input logic [integ_pkg::POS_W-1:0] v);
        @(negedge ref_clk);
        set_load = 1'b1;
        set_value = v;
        @(negedge ref_clk);
        set_load = 1'b0;
    endtask
    // Fetch the stopped pair on its valid pulse
    always @(posedge ref_clk) begin
        if (counts_valid === 1'b1) begin
            got <= counts;
        end
    end
endmodule // proc_model
`default_nettype wire

// ===== testbench/integration_trigger_counters_tb_top.sv
// Purpose: self-checking bench for the integration and trigger counters
// Assumes: short tick and auto period so runs stay brief
// Notes: inputs move on the falling edge, outputs read there too
`timescale 1ns/1ps
`default_nettype none
module integration_trigger_counters_tb_top;
    localparam int TK = 10;
    localparam int AM = 3;
    typedef struct packed {logic [3:0] ns; logic [3:0] nr; logic [63:0] exp;} row_t;
    logic ref_clk = 1'b0, rst_n = 1'b0, signal_pulse_train = 1'b0, reference_pulse_train = 1'b0;
    logic enc_a = 1'b0, enc_b = 1'b0, enc_index = 1'b0, ext_align = 1'b0, over_pos = 1'b0;
    logic over_neg = 1'b0, function_button = 1'b0, gain_change = 1'b0, host_ovr_clear = 1'b0;
    logic get_cmd = 1'b0, init_mode = 1'b0, set_load, trigger, compare, counts_valid;
    logic ovr_pos_ff, ovr_neg_ff;
    logic [23:0] set_value, position;
    integ_pkg::trig_src_t trig_src = integ_pkg::SRC_TIMER;
    integ_pkg::motor_t motor_cmd = 2'h0, motor_out;
    integ_pkg::count_pair_t counts, pm_got;
    int fail_count = 0, samples_checked = 0, idx = 0, n = 0;
    logic [1:0] gray [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    // Zero row lands on a pair used earlier, so it shows the clear
    row_t rows [4] = '{'{4'h5, 4'h7, 64'h0000_0005_0000_0007}, '{4'h0, 4'h3, 64'h0000_0000_0000_0003},
        '{4'h0, 4'h0, 64'h0}, '{4'h2, 4'h0, 64'h0000_0002_0000_0000}};

    integration_trigger_counters #(.TICK_CYCLES(TK), .AUTO_MS(AM)) dut (.ref_clk(ref_clk),
        .rst_n(rst_n), .signal_pulse_train(signal_pulse_train),
        .reference_pulse_train(reference_pulse_train), .enc_a(enc_a), .enc_b(enc_b),
        .enc_index(enc_index), .ext_align(ext_align), .over_pos(over_pos), .over_neg(over_neg),
        .function_button(function_button), .gain_change(gain_change),
        .host_ovr_clear(host_ovr_clear), .get_cmd(get_cmd), .init_mode(init_mode),
        .trig_src(trig_src), .set_load(set_load), .set_value(set_value), .motor_cmd(motor_cmd),
        .counts(counts), .counts_valid(counts_valid), .trigger(trigger), .compare(compare),
        .position(position), .ovr_pos_ff(ovr_pos_ff), .ovr_neg_ff(ovr_neg_ff),
        .motor_out(motor_out));
    proc_model pm (.ref_clk(ref_clk), .counts_valid(counts_valid), .counts(counts),
        .set_load(set_load), .set_value(set_value), .got(pm_got));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Pulse a line; long tail lets the pin synchroniser settle
    task automatic blip(ref logic s, input int w);
        @(negedge ref_clk);
        s = 1'b1;
        repeat (w) @(negedge ref_clk);
        s = 1'b0;
        repeat (10) @(negedge ref_clk);
    endtask
    // Bounded wait; n keeps the gap for period checks
    task automatic wait_trig;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (trigger !== 1'b1 && n < 400);
        check("trigger", 64'h1, {63'h0, trigger});
    endtask
    task automatic pulses(input int ns, input int nr);
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            signal_pulse_train = (i < ns);
            reference_pulse_train = (i < nr);
            repeat (2) @(negedge ref_clk);
            signal_pulse_train = 1'b0;
            reference_pulse_train = 1'b0;
            // Low gap must outlast the filter, or pulses merge
            repeat (2) @(negedge ref_clk);
        end
    endtask
    // Gray steps, b leading a counts up
    task automatic steps(input int k, input int dir);
        repeat (k) begin
            idx = (idx + dir) & 3;
            {enc_a, enc_b} = gray[idx];
            repeat (6) @(negedge ref_clk);
        end
        repeat (6) @(negedge ref_clk);
    endtask

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // Watchdog well beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        results();
    end
    initial begin
        repeat (16) @(negedge ref_clk);
        check("reset outs", 64'h0, 64'({position, trigger, compare, counts_valid, ovr_pos_ff}));
        check("reset counts", 64'h0, counts);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        pm.load(24'h00_000A);
        // Timer intervals from the table
        foreach (rows[i]) begin
            blip(get_cmd, 1);
            pulses(rows[i].ns, rows[i].nr);
            wait_trig();
            check("compare", 64'h1, {63'h0, compare});
            check("position", 64'hA, 64'(position));
            @(negedge ref_clk);
            check("counts_valid", 64'h1, {63'h0, counts_valid});
            check("counts", rows[i].exp, counts);
            @(negedge ref_clk);
            check("fetched", rows[i].exp, pm_got);
        end
        // Overrange latch against each clear source
        for (int k = 0; k < 3; k++) begin
            blip(over_pos, 8);
            blip(over_neg, 8);
            check("ovr set", 64'h3, {62'h0, ovr_pos_ff, ovr_neg_ff});
            if (k == 0)
                blip(function_button, 1);
            else if (k == 1)
                blip(gain_change, 1);
            else
                blip(host_ovr_clear, 1);
            check("ovr clear", 64'h0, {62'h0, ovr_pos_ff, ovr_neg_ff});
        end
        // Encoder counting, sign, index and alignment
        trig_src = integ_pkg::SRC_ENCODER;
        blip(ext_align, 3);
        steps(8, 1);
        check("enc up", 64'h8, 64'(position));
        steps(16, -1);
        check("enc down", 64'hFF_FFF8, 64'(position));
        init_mode = 1'b1;
        blip(enc_index, 3);
        check("index clear", 64'h0, 64'(position));
        init_mode = 1'b0;
        steps(4, 1);
        blip(ext_align, 3);
        check("align clear", 64'h0, 64'(position));
        // Encoder reaches the loaded set value and triggers
        steps(9, 1);
        idx = (idx + 1) & 3;
        {enc_a, enc_b} = gray[idx];
        wait_trig();
        check("enc compare", 64'h1, {63'h0, compare});
        check("enc position", 64'hA, 64'(position));
        repeat (6) @(negedge ref_clk);
        // Motor orders; both at once gives neither
        for (int k = 0; k < 4; k++) begin
            motor_cmd = 2'(k);
            repeat (4) @(negedge ref_clk);
            check("motor", 64'(k == 3 ? 0 : k), 64'(motor_out));
        end
        trig_src = integ_pkg::SRC_AUTO;
        wait_trig();
        wait_trig();
        check("auto period", 64'(AM * TK), 64'(n));
        // Mid-run reset drops latches and counters
        blip(over_pos, 8);
        check("ovr before reset", 64'h1, {63'h0, ovr_pos_ff});
        rst_n = 1'b0;
        @(negedge ref_clk);
        check("mid reset", 64'h0, 64'({position, trigger, compare, counts_valid, ovr_pos_ff}));
        check("mid reset counts", 64'h0, counts);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        check("after reset", 64'h0, {62'h0, ovr_pos_ff, counts_valid});
        results();
    end
endmodule // integration_trigger_counters_tb_top
`default_nettype wire
